// ===== tdh_engine.sv
// descriptor header engine: AHB-Lite slave, buffer memory, list walker
// assumes a link-side USB engine that runs one transaction per request
`default_nettype none

// How it works
// (R1) each header is eight bytes, placed ahead of its payload
// (R2) bytes 0-2: moved count, result, pending, toggle, max length low
// (R3) byte 3 endpoint/last/speed; bytes 4-5 requested count, once, token
// (R4) byte 6 is format flag and 7-bit device address; byte 7 ignored
// (R5) moved byte count field gets bytes actually transferred
// (R6) clean finish writes result 0000
// (R7) checksum error writes 0001, stuffing violation writes 0010
// (R8) data toggle mismatch writes 0011
// (R9) stall retires descriptor with result 0100
// (R10) no reply to IN or no handshake after OUT writes 0101
// (R11) identifier check bit failure writes 0110
// (R12) invalid or undefined identifier writes 0111
// (R13) data beyond max packet or buffer space writes 1000
// (R14) short packet not filling buffer writes 1001
// (R15) codes 1010 and 1011 are never written
// (R16) IN data faster than storage writes 1100
// (R17) OUT fetch too slow for bus rate writes 1101
// (R18) completion clears pending; pending 0 descriptors are skipped
// (R19) list-end flag 1 marks final descriptor of the list
// (R20) format 0 is control/bulk/interrupt, 1 is isochronous
// (R21) data toggle updated after each received data packet
// (R22) header written back before completion is signalled
// (R23) driver sets pending to 1 on each new descriptor
module tdh_engine #(
    parameter int AW = 6
) (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    output logic                         xfer_req,
    output logic [1:0]                   xfer_token,
    output logic [6:0]                   xfer_dev_addr,
    output logic [3:0]                   xfer_endpoint,
    output logic [9:0]                   xfer_max_len,
    output logic [9:0]                   xfer_req_len,
    output logic                         xfer_low_speed,
    output logic                         xfer_iso,
    output logic                         xfer_once,
    output logic                         xfer_toggle,
    input  wire logic                    xfer_done,
    input  wire logic [9:0]              xfer_moved,
    input  wire logic [tdh_pkg::FLG_W-1:0] xfer_flags,
    input  wire logic                    xfer_data_rx,
    input  wire logic                    xfer_toggle_rx,
    output logic                         desc_done,
    output logic                         list_done,
    output logic                         busy
);
    import tdh_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        tdh_state_e    st;
        logic [AW-1:0] idx;
        logic [AW-1:0] base;
        logic [31:0]   w0;
        logic [31:0]   w1;
        logic [3:0]    last_code;
        logic [9:0]    last_moved;
        logic          done_pulse;
        logic          list_end;
        logic          dp_valid;
        logic          dp_write;
        logic          dp_ram;
        logic          dp_second;
        logic [11:0]   dp_addr;
        logic          rd_ram;
        logic [31:0]   rdata;
    } tdh_regs_s;

    tdh_regs_s q;
    tdh_regs_s n;

    tdh_mem_if #(.AW(AW)) mem ();

    tdh_mem #(.AW(AW)) u_mem (
        .hclk    (hclk),
        .hresetn (hresetn),
        .port    (mem.store)
    );

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic is_ram(input logic [11:0] a);
        return (a[11:2] < 10'(2**AW));
    endfunction : is_ram

    function automatic logic [3:0] pick_code(
        input logic [FLG_W-1:0] f,
        input logic [9:0]       moved,
        input logic [9:0]       reqlen,
        input logic [9:0]       maxlen);
        // link-level faults first: without a sane packet nothing else counts
        if (f[FLG_NOREPLY])      return CODE_NO_REPLY;       // (R10)
        else if (f[FLG_IDCHK])   return CODE_ID_CHECK_FAULT; // (R11)
        else if (f[FLG_BADID])   return CODE_BAD_ID;         // (R12)
        else if (f[FLG_STALL])   return CODE_STALL;          // (R9)
        else if (f[FLG_CRC])     return CODE_CRC;            // (R7)
        else if (f[FLG_STUFF])   return CODE_STUFFING;       // (R7)
        else if (f[FLG_SEQ])     return CODE_SEQ_MISMATCH;   // (R8)
        else if (f[FLG_OVER] || moved > reqlen || moved > maxlen)
            return CODE_TOO_MUCH;                            // (R13)
        else if (f[FLG_STORE])   return CODE_STORE_TOO_SLOW; // (R16)
        else if (f[FLG_FETCH])   return CODE_FETCH_TOO_SLOW; // (R17)
        else if (f[FLG_SHORT])   return CODE_SHORT_RETURN;   // (R14)
        else                     return CODE_CLEAN_FINISH;   // (R6)
        // 4'hA and 4'hB have no path here (R15)
    endfunction : pick_code

    // header plus payload rounded up to whole words
    function automatic logic [10:0] span(input logic [9:0] reqlen);
        return 11'(HDR_WORDS) + 11'((11'(reqlen) + 11'd3) >> 2); // (R1)
    endfunction : span

    // ****************************************
    // decoded header fields
    // ****************************************
    logic [9:0] f_max;
    logic [9:0] f_req;
    logic       f_last;
    logic       f_pend;
    logic [3:0] res_code;
    logic [9:0] res_moved;
    logic       res_tog;
    logic [10:0] nxt;
    logic       eng_mem;
    logic       acc;

    assign f_max  = {q.w0[MAX_HI+1:MAX_HI], q.w0[MAX_LO+7:MAX_LO]}; // (R2)
    assign f_req  = {q.w1[REQ_HI+1:REQ_HI], q.w1[REQ_LO+7:REQ_LO]}; // (R3)
    assign f_last = q.w0[LAST];                                      // (R19)
    assign f_pend = q.w0[PEND];
    assign res_code  = pick_code(xfer_flags, xfer_moved, f_req, f_max);
    assign res_moved = xfer_moved;                                   // (R5)
    assign res_tog   = xfer_data_rx ? xfer_toggle_rx : q.w0[TOG];    // (R21)
    assign nxt       = 11'(q.idx) + span(f_req);
    assign eng_mem   = (q.st == ST_FETCH0) || (q.st == ST_FETCH1) ||
                       (q.st == ST_WBACK);
    assign acc       = hsel && htrans[1] && hready;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        n = q;
        n.done_pulse = 1'b0;
        mem.en    = 1'b0;
        mem.we    = 1'b0;
        mem.addr  = q.idx;
        mem.wdata = q.w0;
        hreadyout = 1'b1;

        // descriptor walker; memory priority over the bus
        case (q.st)
            ST_IDLE: begin
            end
            ST_FETCH0: begin
                mem.en = 1'b1;
                n.st   = ST_FETCH1;
            end
            ST_FETCH1: begin
                mem.en   = 1'b1;
                mem.addr = q.idx + AW'(1);
                n.w0     = mem.rdata;
                n.st     = ST_DECODE;
            end
            ST_DECODE: begin
                n.w1 = mem.rdata;
                n.st = f_pend ? ST_EXEC : ST_FINISH;                 // (R18)
            end
            ST_EXEC: begin
                if (xfer_done) begin
                    n.w0[CODE+3:CODE]     = res_code;
                    n.w0[CNT_LO+7:CNT_LO] = res_moved[7:0];
                    n.w0[CNT_HI+1:CNT_HI] = res_moved[9:8];
                    n.w0[TOG]             = res_tog;
                    n.w0[PEND]            = 1'b0;                    // (R18)
                    n.last_code           = res_code;
                    n.last_moved          = res_moved;
                    n.st                  = ST_WBACK;
                end
            end
            ST_WBACK: begin
                // header lands in memory before desc_done rises (R22)
                mem.en     = 1'b1;
                mem.we     = 1'b1;
                n.done_pulse = 1'b1;                                 // (R22)
                n.st       = ST_FINISH;
            end
            ST_FINISH: begin
                if (f_last || nxt >= 11'(2**AW)) begin               // (R19)
                    n.list_end = 1'b1;
                    n.st       = ST_IDLE;
                end else begin
                    n.idx = AW'(nxt);
                    n.st  = ST_FETCH0;
                end
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase

        // AHB-Lite data phase
        if (q.dp_valid) begin
            if (q.dp_write) begin
                if (q.dp_ram) begin
                    if (eng_mem) begin
                        hreadyout = 1'b0;
                    end else begin
                        mem.en    = 1'b1;
                        mem.we    = 1'b1;
                        mem.addr  = q.dp_addr[AW+1:2];
                        mem.wdata = hwdata;
                    end
                end else if (q.dp_addr == OFS_CTRL) begin
                    n.base = hwdata[CTRL_BASE+AW-1:CTRL_BASE];
                    if (hwdata[CTRL_GO] && q.st == ST_IDLE) begin
                        n.idx      = hwdata[CTRL_BASE+AW-1:CTRL_BASE];
                        n.list_end = 1'b0;
                        n.st       = ST_FETCH0;
                    end
                end
            end else if (!q.dp_second) begin
                // reads always take at least one wait state, more while the walker holds memory, so data come from flops
                hreadyout = 1'b0;
                if (q.dp_ram) begin
                    if (!eng_mem) begin
                        mem.en      = 1'b1;
                        mem.addr    = q.dp_addr[AW+1:2];
                        n.dp_second = 1'b1;
                        n.rd_ram    = 1'b1;
                    end
                end else begin
                    n.dp_second = 1'b1;
                    n.rd_ram    = 1'b0;
                    case (q.dp_addr)
                        OFS_CTRL:   n.rdata = 32'(q.base) << CTRL_BASE;
                        OFS_STATUS: n.rdata = {16'h0000, 8'(q.idx),
                                               6'h00, q.list_end,
                                               q.st != ST_IDLE};
                        OFS_RESULT: n.rdata = {18'h00000, q.last_moved,
                                               q.last_code};
                        default:    n.rdata = RST_WORD;
                    endcase
                end
            end
        end

        if (hreadyout) begin
            n.dp_valid  = acc;
            n.dp_write  = hwrite;
            n.dp_addr   = haddr[11:0];
            n.dp_ram    = is_ram(haddr[11:0]);
            n.dp_second = 1'b0;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q.st         <= ST_IDLE;
            q.idx        <= '0;
            q.base       <= '0;
            q.w0         <= RST_WORD;
            q.w1         <= RST_WORD;
            q.last_code  <= RST_CODE;
            q.last_moved <= '0;
            q.done_pulse <= 1'b0;
            q.list_end   <= 1'b0;
            q.dp_valid   <= 1'b0;
            q.dp_write   <= 1'b0;
            q.dp_ram     <= 1'b0;
            q.dp_second  <= 1'b0;
            q.dp_addr    <= '0;
            q.rd_ram     <= 1'b0;
            q.rdata      <= RST_WORD;
        end else begin
            q <= n;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign hresp          = 1'b0;
    assign hrdata         = q.rd_ram ? mem.rdata : q.rdata;
    assign xfer_req       = (q.st == ST_EXEC);
    assign xfer_token     = q.w1[TOKEN+1:TOKEN];                     // (R3)
    assign xfer_dev_addr  = q.w1[DADDR+6:DADDR];                     // (R4)
    assign xfer_endpoint  = q.w0[EP+3:EP];                           // (R3)
    assign xfer_max_len   = f_max;
    assign xfer_req_len   = f_req;
    assign xfer_low_speed = q.w0[SPEED];
    assign xfer_iso       = q.w1[FMT];                               // (R20)
    assign xfer_once      = q.w1[ONCE];
    assign xfer_toggle    = q.w0[TOG];                               // (R2)
    assign desc_done      = q.done_pulse;
    assign list_done      = q.list_end;
    assign busy           = (q.st != ST_IDLE);

endmodule : tdh_engine

`default_nettype wire

// ===== tdh_engine_checker.sv
// port-level checks on the descriptor header engine
// assumes hready is looped back from the engine's own hreadyout
`default_nettype none

module tdh_checker #(
    parameter int AW = 6
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       hsel,
    input  wire logic [1:0] htrans,
    input  wire logic       hwrite,
    input  wire logic       hready,
    input  wire logic       hreadyout,
    input  wire logic       xfer_req,
    input  wire logic [1:0] xfer_token,
    input  wire logic [6:0] xfer_dev_addr,
    input  wire logic [9:0] xfer_req_len,
    input  wire logic       xfer_done,
    input  wire logic       desc_done,
    input  wire logic       busy
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // ****************************************
    // link result and bus read steps
    // ****************************************
    sequence s_result;
        xfer_req && xfer_done;
    endsequence
    sequence s_read;
        hsel && htrans[1] && hready && !hwrite;
    endsequence

    a_req_drops: assert property (s_result |=> !xfer_req)
        else $error("request held after link result");
    a_wback_done: assert property (s_result |-> ##2 desc_done)
        else $error("completion pulse not two cycles after result");
    a_done_pulse: assert property (desc_done |=> !desc_done)
        else $error("completion pulse longer than one cycle");
    a_done_no_req: assert property (desc_done |-> !xfer_req)
        else $error("request raised with completion pulse");
    a_fields_hold: assert property (xfer_req && !xfer_done |=>
        xfer_req && $stable({xfer_token, xfer_dev_addr, xfer_req_len}))
        else $error("decoded fields moved during request");
    a_req_busy: assert property (xfer_req |-> busy)
        else $error("request outside a list walk");
    a_fetch_first: assert property ($rose(xfer_req) |-> $past(busy, 3))
        else $error("request before both header words fetched");
    a_read_wait: assert property (s_read |=> !hreadyout)
        else $error("read answered without wait state");
    a_read_bound: assert property (s_read |-> ##[1:20] hreadyout)
        else $error("read not answered in time");
endmodule : tdh_checker

bind tdh_engine tdh_checker #(.AW(AW)) u_chk (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .hreadyout(hreadyout),
    .xfer_req(xfer_req),
    .xfer_token(xfer_token),
    .xfer_dev_addr(xfer_dev_addr),
    .xfer_req_len(xfer_req_len),
    .xfer_done(xfer_done),
    .desc_done(desc_done),
    .busy(busy)
);

`default_nettype wire

// ===== tdh_engine_test.sv
// self-checking bench: AHB-Lite host driver plus link-side model
// assumes hready of the single slave is its own hreadyout
`default_nettype none

module tdh_engine_test;
    timeunit 1ns;
    timeprecision 1ps;
    import tdh_pkg::*;

    logic             hclk = 1'b0;
    logic             hresetn = 1'b0;
    logic             hsel = 1'b0;
    logic             hwrite = 1'b0;
    logic [1:0]       htrans = 2'h0;
    logic [2:0]       hsize = 3'h2;
    logic [31:0]      haddr = 32'h0;
    logic [31:0]      hwdata = 32'h0;
    logic             hreadyout, hresp, xfer_req, xfer_low_speed;
    logic             xfer_iso, xfer_once, xfer_toggle, xfer_done;
    logic             xfer_data_rx, xfer_toggle_rx, desc_done;
    logic             list_done, busy, rdy_s;
    logic [31:0]      hrdata, rd_s, rd_v;
    logic [1:0]       xfer_token;
    logic [6:0]       xfer_dev_addr;
    logic [3:0]       xfer_endpoint, p_delay = 4'h0;
    logic [9:0]       xfer_max_len, xfer_req_len, xfer_moved;
    logic [FLG_W-1:0] xfer_flags, p_flags = '0;
    int               err_count = 0, n_checks = 0;
    always #5 hclk = ~hclk;
    // bus answer settles well before the edge that samples it
    always @(negedge hclk) begin
        rdy_s = hreadyout;
        rd_s = hrdata;
    end

    tdh_engine uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .xfer_req(xfer_req),
        .xfer_token(xfer_token), .xfer_dev_addr(xfer_dev_addr),
        .xfer_endpoint(xfer_endpoint), .xfer_max_len(xfer_max_len),
        .xfer_req_len(xfer_req_len), .xfer_low_speed(xfer_low_speed),
        .xfer_iso(xfer_iso), .xfer_once(xfer_once),
        .xfer_toggle(xfer_toggle), .xfer_done(xfer_done),
        .xfer_moved(xfer_moved), .xfer_flags(xfer_flags),
        .xfer_data_rx(xfer_data_rx), .xfer_toggle_rx(xfer_toggle_rx),
        .desc_done(desc_done), .list_done(list_done), .busy(busy));

    tdh_link_model u_link (.hclk(hclk), .hresetn(hresetn),
        .xfer_req(xfer_req), .delay(p_delay), .flags(p_flags),
        .xfer_done(xfer_done), .xfer_moved(xfer_moved),
        .xfer_flags(xfer_flags), .xfer_data_rx(xfer_data_rx),
        .xfer_toggle_rx(xfer_toggle_rx));

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    task automatic check(input logic [63:0] got, exp, input string s);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t %s: got %h want %h", $time, s, got, exp);
        end
    endtask : check

    task automatic timed_out();
        err_count++;
        $display("Error %0t wait ran out", $time);
        finish_test();
    endtask : timed_out

    task automatic bus_wait();
        for (int i = 0; i < 50; i++) begin
            @(posedge hclk);
            if (rdy_s === 1'b1)
                return;
        end
        timed_out();
    endtask : bus_wait

    task automatic ahb(input logic w, input logic [31:0] a, d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        bus_wait();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        bus_wait();
        check(64'(hresp), 64'h0, "resp");
        r = rd_s;
    endtask : ahb

    // start a walk at word 0; count completions, keep decoded fields
    task automatic run(output int n, output logic [63:0] f);
        logic [31:0] r;
        n = 0;
        f = '0;
        ahb(1'b1, {20'h0, OFS_CTRL}, 32'h1, r);
        for (int i = 0; i < 400; i++) begin
            @(negedge hclk);
            if (xfer_req)
                f = {27'h0, xfer_token, xfer_dev_addr, xfer_endpoint,
                     xfer_max_len, xfer_req_len, xfer_low_speed,
                     xfer_iso, xfer_once, xfer_toggle};
            if (desc_done)
                n++;
            if (list_done && i > 1)
                return;
        end
        timed_out();
    endtask : run

    // ****************************************
    // scenarios
    // ****************************************
    // one descriptor per outcome flag, then a clean one
    task automatic t_codes();
        logic [3:0]  code [12] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
                                  4'h7, 4'h8, 4'h9, 4'hC, 4'hD, 4'h0};
        logic [31:0] r;
        logic [63:0] f, e;
        logic [1:0]  tok;
        logic        fmt;
        int          n;
        for (int i = 0; i < 12; i++) begin
            tok = 2'(i % 3);
            fmt = i[0];
            ahb(1'b1, 32'h0, {16'h5C40, 4'hF, 12'hBFF}, r);
            ahb(1'b1, 32'h4, {8'hA5, fmt, 7'h2A, 2'h0, fmt, 1'b0, tok,
                              10'h008}, r);
            p_flags <= (i < 11) ? 11'h1 << i : 11'h0;
            p_delay <= 4'(i);
            run(n, f);
            e = {27'h0, tok, 7'h2A, 4'h5, 10'h040, 10'h008, 1'b1, fmt, fmt,
                 1'b0};
            check(f, e, "fields");
            check(64'(n), 64'h1, "done");
            ahb(1'b0, 32'h0, 32'h0, r);
            e = {32'h0, 16'h5C40, code[i], 12'h404};
            check(64'(r), e, "w0");
            ahb(1'b0, {20'h0, OFS_RESULT}, 32'h0, r);
            e = {50'h0, 10'h004, code[i]};
            check(64'(r[13:0]), e, "rs");
        end
    endtask : t_codes

    // skipped head, two live ones, list end before a live spare
    task automatic t_list();
        logic [31:0] a [8] = '{32'h00, 32'h04, 32'h10, 32'h14,
                               32'h18, 32'h1C, 32'h20, 32'h24};
        logic [31:0] d [8] = '{32'h5440F3FF, 32'h002A0808,
                               32'h5440FBFF, 32'h002A0800,
                               32'h5C40FBFF, 32'h002A0800,
                               32'h5C40FBFF, 32'h002A0800};
        logic [31:0] r;
        logic [63:0] f;
        int          n;
        for (int i = 0; i < 8; i++)
            ahb(1'b1, a[i], d[i], r);
        p_flags <= 11'h0;
        p_delay <= 4'h0;
        run(n, f);
        check(64'(n), 64'h2, "first pass");
        ahb(1'b0, 32'h0, 32'h0, r);
        check(64'(r), 64'h5440F3FF, "skipped");
        ahb(1'b0, 32'h18, 32'h0, r);
        check(64'(r[11]), 64'h0, "pending");
        run(n, f);
        check(64'(n), 64'h0, "second pass");
    endtask : t_list

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_codes();
        t_list();
        ahb(1'b0, 32'h200, 32'h0, rd_v);
        check(64'(rd_v), 64'h0, "unmapped");
        finish_test();
    end
endmodule : tdh_engine_test

`default_nettype wire

// ===== tdh_link_model.sv
// link-side endpoint model: answers each transaction request once
// assumes the engine holds xfer_req until it samples the result pulse
`default_nettype none

module tdh_link_model #(
    parameter logic [9:0] MOVED = 10'h004
) (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      xfer_req,
    input  wire logic [3:0]                delay,
    input  wire logic [tdh_pkg::FLG_W-1:0] flags,
    output logic                           xfer_done,
    output logic [9:0]                     xfer_moved,
    output logic [tdh_pkg::FLG_W-1:0]      xfer_flags,
    output logic                           xfer_data_rx,
    output logic                           xfer_toggle_rx
);
    import tdh_pkg::*;
    logic [3:0] wait_cnt;

    // off the pulse show junk, so a stale sample cannot look right
    assign xfer_moved     = xfer_done ? MOVED : ~MOVED;
    assign xfer_flags     = xfer_done ? flags : ~flags;
    assign xfer_data_rx   = xfer_done;
    assign xfer_toggle_rx = xfer_done;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt  <= 4'h0;
            xfer_done <= 1'b0;
        end else begin
            xfer_done <= 1'b0;
            if (xfer_req && !xfer_done) begin
                if (wait_cnt == delay) begin
                    xfer_done <= 1'b1;
                    wait_cnt  <= 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
        end
    end
endmodule : tdh_link_model

`default_nettype wire

// ===== tdh_mem.sv
// single-port word memory holding descriptor headers and payloads
// assumes one access per clock; read data registered
`default_nettype none

module tdh_mem #(
    parameter int AW = 6
) (
    input  wire logic   hclk,
    input  wire logic   hresetn,
    tdh_mem_if.store    port
);
    import tdh_pkg::*;

    logic [31:0] words [2**AW];

    always_ff @(posedge hclk) begin
        if (port.en && port.we) begin
            words[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port.rdata <= RST_WORD;
        end else if (port.en && !port.we) begin
            port.rdata <= words[port.addr];
        end
    end
endmodule : tdh_mem

`default_nettype wire

// ===== tdh_mem_if.sv
// port bundle between the engine and its buffer memory
// assumes the memory answers a read one clock later
`default_nettype none

interface tdh_mem_if #(parameter int AW = 6);
    logic          en;
    logic          we;
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
    logic [31:0]   rdata;

    modport owner (output en, output we, output addr, output wdata,
                   input rdata);
    modport store (input en, input we, input addr, input wdata,
                   output rdata);
endinterface : tdh_mem_if

`default_nettype wire

// ===== tdh_pkg.sv
// constants and types for the transfer descriptor header engine
// assumes one 100 MHz clock domain, AHB-Lite register access
`default_nettype none

package tdh_pkg;

    // ****************************************
    // register map (byte offsets, low 12 bits)
    // ****************************************
    localparam logic [11:0] OFS_CTRL   = 12'h100;
    localparam logic [11:0] OFS_STATUS = 12'h104;
    localparam logic [11:0] OFS_RESULT = 12'h108;
    localparam int          CTRL_GO    = 0;
    localparam int          CTRL_BASE  = 8;

    // ****************************************
    // header word 0 (bytes 0..3) fields
    // ****************************************
    localparam int CNT_LO  = 0;
    localparam int CNT_HI  = 8;
    localparam int TOG     = 10;
    localparam int PEND    = 11;
    localparam int CODE    = 12;
    localparam int MAX_LO  = 16;
    localparam int MAX_HI  = 24;
    localparam int SPEED   = 26;
    localparam int LAST    = 27;
    localparam int EP      = 28;

    // ****************************************
    // header word 1 (bytes 4..7) fields
    // ****************************************
    localparam int REQ_LO  = 0;
    localparam int REQ_HI  = 8;
    localparam int TOKEN   = 10;
    localparam int ONCE    = 13;
    localparam int DADDR   = 16;
    localparam int FMT     = 23;
    localparam int HDR_WORDS = 2;

    // ****************************************
    // transaction outcome flags from the link side
    // ****************************************
    localparam int FLG_CRC     = 0;
    localparam int FLG_STUFF   = 1;
    localparam int FLG_SEQ     = 2;
    localparam int FLG_STALL   = 3;
    localparam int FLG_NOREPLY = 4;
    localparam int FLG_IDCHK   = 5;
    localparam int FLG_BADID   = 6;
    localparam int FLG_OVER    = 7;
    localparam int FLG_SHORT   = 8;
    localparam int FLG_STORE   = 9;
    localparam int FLG_FETCH   = 10;
    localparam int FLG_W       = 11;

    typedef enum logic [3:0] {
        CODE_CLEAN_FINISH   = 4'h0,
        CODE_CRC            = 4'h1,
        CODE_STUFFING       = 4'h2,
        CODE_SEQ_MISMATCH   = 4'h3,
        CODE_STALL          = 4'h4,
        CODE_NO_REPLY       = 4'h5,
        CODE_ID_CHECK_FAULT = 4'h6,
        CODE_BAD_ID         = 4'h7,
        CODE_TOO_MUCH       = 4'h8,
        CODE_SHORT_RETURN   = 4'h9,
        CODE_STORE_TOO_SLOW = 4'hC,
        CODE_FETCH_TOO_SLOW = 4'hD
    } tdh_code_e;

    typedef enum logic [1:0] {
        TOK_SETUP = 2'h0,
        TOK_OUT   = 2'h1,
        TOK_IN    = 2'h2
    } tdh_token_e;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_FETCH0 = 3'b001,
        ST_FETCH1 = 3'b010,
        ST_DECODE = 3'b011,
        ST_EXEC   = 3'b100,
        ST_WBACK  = 3'b101,
        ST_FINISH = 3'b110
    } tdh_state_e;

    localparam logic [3:0]  RST_CODE = 4'h0;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

endpackage : tdh_pkg

`default_nettype wire
